//--- ilk_top.sv
// teach-in, lock and safety-output control of a guard-locking switch
// assumes synchronous inputs, supply_ok low while operating power is removed,
// and code/teach bookkeeping registers that model non-volatile storage
`timescale 1ns/1ps
module ilk_top #(
	parameter logic [39:0] TEACH_SWITCH_CYC = 40'(ilk_pkg::TEACH_SWITCH_CYC),
	parameter logic [39:0] TEACH_ABORT_CYC = 40'(ilk_pkg::TEACH_ABORT_CYC),
	parameter logic [39:0] INHIBIT_CYC = 40'(ilk_pkg::INHIBIT_CYC),
	parameter logic [39:0] BLINK1_HALF_CYC = 40'(ilk_pkg::BLINK1_HALF_CYC),
	parameter logic [39:0] BLINK3_HALF_CYC = 40'(ilk_pkg::BLINK3_HALF_CYC)
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire logic supply_ok,
	input wire logic actuator_present,
	input wire logic [15:0] actuator_code,
	input wire logic guard_closed,
	input wire logic mag_cmd,
	input wire logic safety_feed_a,
	input wire logic safety_feed_b,
	input wire logic serial_diag_in,
	output logic serial_diag_chain,
	output logic safety_output_a,
	output logic safety_output_b,
	output logic lock_solenoid,
	output ilk_pkg::ilk_leds_s leds
);

	// true on the last cycle of a period of lim cycles
	function automatic logic period_hit(input logic [39:0] cnt, input logic [39:0] lim);
		period_hit = (cnt >= lim - 40'h1);
	endfunction

	ilk_pkg::ilk_cfg_s cfg_ff;
	ilk_pkg::ilk_state_e state_ff;
	logic supply_q_ff;
	logic fresh_ff;
	logic [39:0] phase_cnt_ff;
	logic [39:0] inhib_cnt_ff;
	logic [15:0] cand_code_ff;
	logic [15:0] stored_code_ff;
	logic code_valid_ff;
	logic [15:0] pending_code_ff;
	logic pending_ff;
	logic teach_used_ff;
	logic inhibit_pend_ff;
	logic seen_new_ff;
	logic mag_sync1_ff;
	logic mag_sync2_ff;
	logic mag_stable_ff;
	logic [11:0] deb_cnt_ff;
	logic [39:0] blink1_cnt_ff;
	logic [39:0] blink3_cnt_ff;
	logic blink1_ff;
	logic blink3_ff;
	logic [4:0] flash_seq_ff;
	logic wb_ack_ff;

	logic power_up;
	logic match;
	logic teach_allowed;
	logic lock_req;
	logic inhibit_done;
	logic nxt_enable;
	logic tick1;
	logic red_code;
	logic activate;
	logic wb_take;

	assign power_up = supply_ok & ~supply_q_ff;
	assign tick1 = period_hit(blink1_cnt_ff, BLINK1_HALF_CYC);
	assign inhibit_done = (inhib_cnt_ff >= INHIBIT_CYC);
	// standard coding takes any actuator, individual coding needs the stored code
	assign match = actuator_present &
		(cfg_ff.teachable ? (code_valid_ff & (actuator_code == stored_code_ff)) : 1'b1);
	assign teach_allowed = cfg_ff.teachable &
		(cfg_ff.repeat_teach_variant | ~teach_used_ff);
	// lock_req is high while the guard is meant to be locked
	assign lock_req = cfg_ff.power_to_lock ? mag_stable_ff : ~mag_stable_ff;
	// red burst: five on/off pulses, then a pause
	assign red_code = (flash_seq_ff < 5'(2 * ilk_pkg::FAULT_FLASHES)) & ~flash_seq_ff[0];
	// the taught code goes live on the first matching detection after power returns
	assign activate = (state_ff == ilk_pkg::ST_RUN) & pending_ff & actuator_present
		& (actuator_code == pending_code_ff);
	assign wb_take = wb_cyc_i & wb_stb_i & ~wb_ack_ff;

	// outputs need a matching actuator, closed guard, healthy chain and no inhibit
	always_comb begin
		nxt_enable = supply_ok & (state_ff == ilk_pkg::ST_RUN) & match & ~inhibit_pend_ff
			& guard_closed & safety_feed_a & safety_feed_b;
		if (!cfg_ff.door_monitor) begin
			nxt_enable = nxt_enable & lock_req;
		end
	end

	// magnet command line conditioning
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mag_sync1_ff <= 1'b0;
			mag_sync2_ff <= 1'b0;
			mag_stable_ff <= 1'b0;
			deb_cnt_ff <= 12'h000;
		end else begin
			mag_sync1_ff <= mag_cmd;
			mag_sync2_ff <= mag_sync1_ff;
			if (mag_sync2_ff == mag_stable_ff) begin
				deb_cnt_ff <= 12'h000;
			end else if (deb_cnt_ff == ilk_pkg::DEBOUNCE_CYC - 12'h001) begin
				mag_stable_ff <= mag_sync2_ff;
				deb_cnt_ff <= 12'h000;
			end else begin
				deb_cnt_ff <= deb_cnt_ff + 12'h001;
			end
		end
	end

	// blink generators
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			blink1_cnt_ff <= 40'h0;
			blink3_cnt_ff <= 40'h0;
			blink1_ff <= 1'b0;
			blink3_ff <= 1'b0;
			flash_seq_ff <= 5'h00;
		end else if (!supply_ok) begin
			blink1_cnt_ff <= 40'h0;
			blink3_cnt_ff <= 40'h0;
			blink1_ff <= 1'b0;
			blink3_ff <= 1'b0;
			flash_seq_ff <= 5'h00;
		end else begin
			if (tick1) begin
				blink1_cnt_ff <= 40'h0;
				blink1_ff <= ~blink1_ff;
				if (state_ff != ilk_pkg::ST_ABORT ||
					flash_seq_ff == ilk_pkg::FLASH_SEQ_LEN - 5'h01) begin
					flash_seq_ff <= 5'h00;
				end else begin
					flash_seq_ff <= flash_seq_ff + 5'h01;
				end
			end else begin
				blink1_cnt_ff <= blink1_cnt_ff + 40'h1;
			end
			if (period_hit(blink3_cnt_ff, BLINK3_HALF_CYC)) begin
				blink3_cnt_ff <= 40'h0;
				blink3_ff <= ~blink3_ff;
			end else begin
				blink3_cnt_ff <= blink3_cnt_ff + 40'h1;
			end
		end
	end

	// power-up detection and the post-power-cycle teach window
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			supply_q_ff <= 1'b0;
			fresh_ff <= 1'b0;
		end else begin
			supply_q_ff <= supply_ok;
			if (power_up) begin
				fresh_ff <= 1'b1;
			end else if (!supply_ok || (actuator_present && state_ff == ilk_pkg::ST_RUN)) begin
				fresh_ff <= 1'b0;
			end
		end
	end

	// teach sequence; code bookkeeping survives supply loss like stored memory
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ilk_pkg::ST_RUN;
			phase_cnt_ff <= 40'h0;
			cand_code_ff <= 16'h0000;
			stored_code_ff <= 16'h0000;
			code_valid_ff <= 1'b0;
			pending_code_ff <= 16'h0000;
			pending_ff <= 1'b0;
			teach_used_ff <= 1'b0;
		end else if (!supply_ok) begin
			state_ff <= ilk_pkg::ST_RUN;
			phase_cnt_ff <= 40'h0;
		end else begin
			case (state_ff)
			ilk_pkg::ST_RUN: begin
				phase_cnt_ff <= 40'h0;
				if (activate) begin
					stored_code_ff <= pending_code_ff;
					code_valid_ff <= 1'b1;
					pending_ff <= 1'b0;
					teach_used_ff <= 1'b1;
				end else if (fresh_ff && teach_allowed && actuator_present && !match
					&& !pending_ff && !inhibit_pend_ff) begin
					cand_code_ff <= actuator_code;
					state_ff <= ilk_pkg::ST_TEACH;
				end
			end
			ilk_pkg::ST_TEACH: begin
				if (!actuator_present) begin
					state_ff <= ilk_pkg::ST_RUN;
				end else if (phase_cnt_ff >= TEACH_SWITCH_CYC - 40'h1) begin
					pending_code_ff <= cand_code_ff;
					pending_ff <= 1'b1;
					phase_cnt_ff <= 40'h0;
					state_ff <= ilk_pkg::ST_PWRREQ;
				end else begin
					phase_cnt_ff <= phase_cnt_ff + 40'h1;
				end
			end
			ilk_pkg::ST_PWRREQ: begin
				if (phase_cnt_ff >= TEACH_ABORT_CYC - 40'h1) begin
					pending_ff <= 1'b0;
					state_ff <= ilk_pkg::ST_ABORT;
				end else begin
					phase_cnt_ff <= phase_cnt_ff + 40'h1;
				end
			end
			ilk_pkg::ST_ABORT: begin
				// held until the supply is cycled
				phase_cnt_ff <= 40'h0;
			end
			default: begin
				state_ff <= ilk_pkg::ST_RUN;
			end
			endcase
		end
	end

	// anti-tamper enabling inhibit
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			inhibit_pend_ff <= 1'b0;
			inhib_cnt_ff <= 40'h0;
			seen_new_ff <= 1'b0;
		end else if (!supply_ok) begin
			// a supply loss restarts the full inhibit period
			inhib_cnt_ff <= 40'h0;
			seen_new_ff <= 1'b0;
		end else if (activate) begin
			inhibit_pend_ff <= 1'b1;
			inhib_cnt_ff <= 40'h0;
			seen_new_ff <= 1'b1;
		end else if (inhibit_pend_ff) begin
			if (match) begin
				seen_new_ff <= 1'b1;
			end
			if (!inhibit_done) begin
				inhib_cnt_ff <= inhib_cnt_ff + 40'h1;
			end else if (seen_new_ff || match) begin
				inhibit_pend_ff <= 1'b0;
			end
		end
	end

	// pins
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			safety_output_a <= 1'b0;
			safety_output_b <= 1'b0;
			lock_solenoid <= 1'b0;
			serial_diag_chain <= 1'b0;
		end else begin
			// both channels switch together from one registered enable
			safety_output_a <= nxt_enable;
			safety_output_b <= nxt_enable;
			lock_solenoid <= supply_ok & mag_stable_ff;
			serial_diag_chain <= supply_ok & serial_diag_in;
		end
	end

	// indicator LEDs
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			leds <= '0;
		end else if (!supply_ok) begin
			leds <= '0;
		end else begin
			case (state_ff)
			ilk_pkg::ST_TEACH: begin
				leds <= '{green: 1'b0, yellow: blink1_ff, red: 1'b1};
			end
			ilk_pkg::ST_PWRREQ: begin
				leds <= '{green: 1'b0, yellow: blink3_ff, red: 1'b1};
			end
			ilk_pkg::ST_ABORT: begin
				leds <= '{green: 1'b1, yellow: 1'b0, red: red_code};
			end
			default: begin
				// run: green steady, flashing while the enabling inhibit runs
				leds.green <= inhibit_pend_ff ? blink1_ff : 1'b1;
				leds.yellow <= nxt_enable | (match & guard_closed & blink1_ff);
				leds.red <= 1'b0;
			end
			endcase
		end
	end

	// wishbone slave: one wait state, ack is a single-cycle pulse
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_ff <= 1'b0;
		end else begin
			wb_ack_ff <= wb_take;
		end
	end

	// configuration register, written through byte lane 0 only
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_ff <= ilk_pkg::CFG_RST;
		end else if (wb_take && wb_we_i && wb_sel_i[0] && wb_adr_i == ilk_pkg::REG_CFG) begin
			cfg_ff <= wb_dat_i[4:0];
		end
	end

	// read data loads on the take edge and holds; unmapped reads return zero
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_dat_o <= 32'h00000000;
		end else if (wb_take) begin
			case (wb_adr_i)
			ilk_pkg::REG_CFG: begin
				wb_dat_o <= {27'h0, cfg_ff};
			end
			ilk_pkg::REG_STAT: begin
				wb_dat_o <= {20'h0, state_ff, inhibit_pend_ff, pending_ff, code_valid_ff,
					teach_used_ff, lock_req, nxt_enable, leds};
			end
			ilk_pkg::REG_CODE: begin
				wb_dat_o <= {pending_code_ff, stored_code_ff};
			end
			default: begin
				wb_dat_o <= 32'h00000000;
			end
			endcase
		end
	end

	assign wb_ack_o = wb_ack_ff;

endmodule

//--- ilk_pkg.sv
// constants, types and register map of the guard-locking teach/lock controller
// assumes one 250 MHz clock and a classic wishbone slave with byte addressing
package ilk_pkg;

	localparam longint CLK_HZ = 64'd250000000;

	// printed times in their own units
	localparam longint TEACH_SWITCH_S = 64'd10;
	localparam longint TEACH_ABORT_MIN = 64'd5;
	localparam longint INHIBIT_MIN = 64'd10;
	localparam longint TEACH_BLINK_HZ = 64'd1;
	localparam longint PWRREQ_BLINK_HZ = 64'd3;
	localparam longint DEBOUNCE_US = 64'd10;
	localparam int FAULT_FLASHES = 5;

	// derived cycle counts; blink half periods round down, debounce rounds up
	localparam longint TEACH_SWITCH_CYC = CLK_HZ * TEACH_SWITCH_S;
	localparam longint TEACH_ABORT_CYC = CLK_HZ * 64'd60 * TEACH_ABORT_MIN;
	localparam longint INHIBIT_CYC = CLK_HZ * 64'd60 * INHIBIT_MIN;
	localparam longint BLINK1_HALF_CYC = CLK_HZ / (64'd2 * TEACH_BLINK_HZ);
	localparam longint BLINK3_HALF_CYC = CLK_HZ / (64'd2 * PWRREQ_BLINK_HZ);
	localparam longint DEBOUNCE_CYC_L = (CLK_HZ * DEBOUNCE_US + 64'd999999) / 64'd1000000;
	localparam logic [11:0] DEBOUNCE_CYC = 12'(DEBOUNCE_CYC_L);

	// red flash code: on/off half periods per burst plus a pause
	localparam logic [4:0] FLASH_SEQ_LEN = 5'(2 * FAULT_FLASHES + 4);

	localparam int TIMER_W = 40;
	localparam int CODE_W = 16;

	// register byte offsets
	localparam logic [3:0] REG_CFG = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_CODE = 4'h8;

	// config field positions
	localparam int CFG_TEACHABLE = 0;
	localparam int CFG_SINGLE = 1;
	localparam int CFG_REPEAT = 2;
	localparam int CFG_DOOR_MON = 3;
	localparam int CFG_PWR_LOCK = 4;
	localparam logic [4:0] CFG_RST = 5'h00;

	typedef enum logic [2:0] {
		ST_RUN = 3'h0,
		ST_TEACH = 3'h1,
		ST_PWRREQ = 3'h3,
		ST_ABORT = 3'h2
	} ilk_state_e;

	typedef struct packed {
		logic green;
		logic yellow;
		logic red;
	} ilk_leds_s;

	typedef struct packed {
		logic power_to_lock;
		logic door_monitor;
		logic repeat_teach_variant;
		logic single_teach_variant;
		logic teachable;
	} ilk_cfg_s;

endpackage

//--- ilk_far_model.sv
// far side: next chained unit on the feeds, dual-channel monitor, diag gateway
// assumes the bench says when the chain ahead is healthy
`timescale 1ns/1ps
module ilk_far_model (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic chain_ok,
	input wire logic safety_output_a,
	input wire logic safety_output_b,
	input wire logic serial_diag_chain,
	output logic safety_feed_a,
	output logic safety_feed_b,
	output logic serial_diag_in,
	output logic diag_seen_ff,
	output logic discrepancy_ff
);
	assign safety_feed_a = chain_ok;
	assign safety_feed_b = chain_ok;
	// gateway feeds the first unit a pattern that changes every cycle
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			serial_diag_in <= 1'b0;
			diag_seen_ff <= 1'b0;
			discrepancy_ff <= 1'b0;
		end else begin
			serial_diag_in <= ~serial_diag_in;
			diag_seen_ff <= diag_seen_ff | (serial_diag_chain & ~serial_diag_in);
			discrepancy_ff <= discrepancy_ff | (safety_output_a != safety_output_b);
		end
	end
endmodule

//--- ilk_top_assertions.sv
// port-level checks of the interlock controller
// assumes one clock domain and the shortened counts of the bench
`timescale 1ns/1ps
module ilk_top_assertions (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic supply_ok,
	input wire logic guard_closed,
	input wire logic mag_cmd,
	input wire logic safety_feed_a,
	input wire logic serial_diag_in,
	input wire logic serial_diag_chain,
	input wire logic safety_output_a,
	input wire logic safety_output_b,
	input wire logic lock_solenoid,
	input ilk_pkg::ilk_leds_s leds
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	logic mag_d_ff;
	logic [11:0] quiet_ff;
	// cycles the magnet line has held still, saturating
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mag_d_ff <= 1'b0;
			quiet_ff <= 12'h000;
		end else begin
			mag_d_ff <= mag_cmd;
			quiet_ff <= (mag_cmd != mag_d_ff) ? 12'h000 : quiet_ff + {11'h000, quiet_ff != 12'hfff};
		end
	end
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	property p_ack; s_take |=> s_ack_pulse; endproperty
	a_ack: assert property (p_ack) else $error("ack not a one-cycle answer");
	property p_pair; safety_output_a == safety_output_b; endproperty
	a_pair: assert property (p_pair) else $error("safety outputs differ");
	property p_nopwr; !supply_ok |=> !safety_output_a && leds == 3'h0; endproperty
	a_nopwr: assert property (p_nopwr) else $error("active while unpowered");
	property p_feed; !safety_feed_a |=> !safety_output_a; endproperty
	a_feed: assert property (p_feed) else $error("output on without feed");
	property p_guard; !guard_closed |=> !safety_output_a; endproperty
	a_guard: assert property (p_guard) else $error("output on with guard open");
	property p_green; safety_output_a |-> leds.green && !leds.red; endproperty
	a_green: assert property (p_green) else $error("led state wrong while enabled");
	property p_diag;
		supply_ok && $past(supply_ok) && $past(arst_n) |-> serial_diag_chain == $past(serial_diag_in);
	endproperty
	a_diag: assert property (p_diag) else $error("diag chain copy wrong");
	property p_debounce;
		supply_ok && $past(supply_ok) && $changed(lock_solenoid)
			|-> quiet_ff >= 12'h960 && lock_solenoid == mag_cmd;
	endproperty
	a_debounce: assert property (p_debounce) else $error("solenoid moved early");
endmodule
bind ilk_top ilk_top_assertions u_chk (.sys_clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.supply_ok, .guard_closed, .mag_cmd, .safety_feed_a, .serial_diag_in, .serial_diag_chain,
	.safety_output_a, .safety_output_b, .lock_solenoid, .leds);

//--- tb_interlock_teach_lock_control.sv
// self-checking bench of the interlock controller with its far-side model
// assumes shortened teach, abort, inhibit and blink counts
`timescale 1ns/1ps
module tb_interlock_teach_lock_control;
	logic sys_clk, arst_n, wb_ack_o, feed_a, feed_b, diag_in, diag_out, diag_seen, disc;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, supply_ok = 1'b0, chain_ok = 1'b1;
	logic actuator_present = 1'b1, guard_closed = 1'b1, mag_cmd = 1'b0;
	logic [3:0] wb_adr_i = 4'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [15:0] actuator_code = 16'h1234;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic safety_output_a, safety_output_b, lock_solenoid;
	ilk_pkg::ilk_leds_s leds;
	int n_errors = 0, total_checks = 0, k, r;
	ilk_top #(.TEACH_SWITCH_CYC(40'h64), .TEACH_ABORT_CYC(40'h12c), .INHIBIT_CYC(40'h1f4),
		.BLINK1_HALF_CYC(40'h8), .BLINK3_HALF_CYC(40'h3)) uut (.sys_clk, .arst_n, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .supply_ok,
		.actuator_present, .actuator_code, .guard_closed, .mag_cmd, .safety_feed_a(feed_a),
		.safety_feed_b(feed_b), .serial_diag_in(diag_in), .serial_diag_chain(diag_out),
		.safety_output_a, .safety_output_b, .lock_solenoid, .leds);
	ilk_far_model far (.sys_clk, .arst_n, .chain_ok, .safety_output_a, .safety_output_b,
		.serial_diag_chain(diag_out), .safety_feed_a(feed_a), .safety_feed_b(feed_b),
		.serial_diag_in(diag_in), .diag_seen_ff(diag_seen), .discrepancy_ff(disc));
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
		int i;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= 4'hf;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 20);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_sel_i <= 4'h0;
		chk("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
		if (wb_ack_o !== 1'b1) summarize();
		@(posedge sys_clk);
	endtask
	task automatic wait_out(input logic exp, input int bound);
		int i;
		for (i = 0; i < bound && safety_output_a !== exp; i++) @(posedge sys_clk);
		chk("safety_output_a", {31'h0, exp}, {31'h0, safety_output_a});
		if (safety_output_a !== exp) summarize();
	endtask
	task automatic pwr;
		supply_ok <= 1'b0;
		cyc(4);
		supply_ok <= 1'b1;
		cyc(2);
	endtask
	task automatic set_mag(input logic v);
		mag_cmd <= v;
		cyc(2700);
	endtask
	task automatic watch(input int b, input int n);
		logic p;
		k = 0;
		r = 0;
		p = leds[b];
		repeat (n) begin
			@(posedge sys_clk);
			k += int'(leds[b] !== p);
			r += int'(leds[b] === 1'b1 && p === 1'b0);
			p = leds[b];
		end
	endtask
	task automatic t_regs;
		wb(1'b0, ilk_pkg::REG_CFG, 32'h0);
		chk("cfg reset", 32'h0, rd);
		wb(1'b1, ilk_pkg::REG_CFG, 32'h1f);
		wb(1'b0, ilk_pkg::REG_CFG, 32'h0);
		chk("cfg", 32'h1f, rd);
		wb(1'b1, 4'hc, 32'hffff_ffff);
		wb(1'b0, 4'hc, 32'h0);
		chk("unmapped", 32'h0, rd);
		wb(1'b1, ilk_pkg::REG_CFG, 32'h0);
	endtask
	task automatic t_std;
		supply_ok <= 1'b1;
		cyc(2700);
		wait_out(1'b1, 20);
		chk("lock_solenoid", 32'h0, {31'h0, lock_solenoid});
		set_mag(1'b1);
		chk("lock_solenoid", 32'h1, {31'h0, lock_solenoid});
		wait_out(1'b0, 4);
		mag_cmd <= 1'b0;
		cyc(100);
		set_mag(1'b1);
		chk("lock_solenoid", 32'h1, {31'h0, lock_solenoid});
		set_mag(1'b0);
		wait_out(1'b1, 4);
		chain_ok <= 1'b0;
		wait_out(1'b0, 4);
		chain_ok <= 1'b1;
		wait_out(1'b1, 4);
		chk("diag echo", 32'h1, {31'h0, diag_seen & ~disc});
	endtask
	task automatic t_pol;
		wb(1'b1, ilk_pkg::REG_CFG, 32'h10);
		wait_out(1'b0, 8);
		set_mag(1'b1);
		wait_out(1'b1, 4);
		wb(1'b1, ilk_pkg::REG_CFG, 32'h08);
		wait_out(1'b1, 8);
		guard_closed <= 1'b0;
		wait_out(1'b0, 4);
		guard_closed <= 1'b1;
	endtask
	task automatic t_abort;
		wb(1'b1, ilk_pkg::REG_CFG, 32'h0d);
		pwr();
		cyc(3);
		chk("teach leds", 32'h1, {30'h0, leds.green, leds.red});
		watch(1, 32);
		chk("yellow 1hz", 32'h1, {31'h0, k >= 3 && k <= 5});
		cyc(70);
		wb(1'b0, ilk_pkg::REG_STAT, 32'h0);
		chk("state", 32'h3, {29'h0, rd[11:9]});
		watch(1, 12);
		chk("yellow 3hz", 32'h1, {31'h0, k >= 3 && k <= 5});
		cyc(310);
		wb(1'b0, ilk_pkg::REG_STAT, 32'h0);
		chk("state", 32'h2, {29'h0, rd[11:9]});
		chk("safety_output_a", 32'h0, {31'h0, safety_output_a});
		watch(0, 112);
		chk("red pulses", 32'h5, r);
	endtask
	task automatic t_learn(input logic [15:0] code);
		actuator_code <= code;
		pwr();
		cyc(110);
		pwr();
		cyc(4);
		wb(1'b0, ilk_pkg::REG_CODE, 32'h0);
		chk("stored code", {16'h0, code}, {16'h0, rd[15:0]});
		wb(1'b0, ilk_pkg::REG_STAT, 32'h0);
		chk("code valid", 32'h1, {31'h0, rd[6]});
		chk("safety_output_a", 32'h0, {31'h0, safety_output_a});
		watch(2, 40);
		chk("green flash", 32'h1, {31'h0, k >= 3});
		pwr();
		cyc(440);
		chk("safety_output_a", 32'h0, {31'h0, safety_output_a});
		wait_out(1'b1, 120);
		watch(2, 40);
		chk("green steady", 32'h0, k);
	endtask
	task automatic t_single;
		actuator_code <= 16'h1234;
		wait_out(1'b0, 4);
		wb(1'b1, ilk_pkg::REG_CFG, 32'h0b);
		actuator_code <= 16'h9abc;
		pwr();
		cyc(150);
		wb(1'b0, ilk_pkg::REG_STAT, 32'h0);
		chk("state", 32'h0, {29'h0, rd[11:9]});
	endtask
	initial begin
		arst_n = 1'b0;
		cyc(5);
		arst_n <= 1'b1;
		cyc(1);
		t_regs();
		t_std();
		t_pol();
		t_abort();
		t_learn(16'h1234);
		t_learn(16'h5678);
		t_single();
		summarize();
	end
	initial begin
		cyc(90000);
		n_errors++;
		summarize();
	end
endmodule
